// ---- ms_pkg.sv ----
// Shared constants and types of the mastering and statistics unit
package ms_pkg;
  localparam int N_SLOT     = 10;
  localparam int SIG_W      = 8;
  localparam int VAL_W      = 32;
  localparam int DEP_W      = 4;
  localparam int CODE_W     = 10;
  localparam int FIFO_DEPTH = 8;

  // Master value limit, values are in nanometres (six decimals of a mm)
  localparam logic signed [VAL_W-1:0] MASTER_LIM = 32'sh0147_9B30;

  // Stats depth as log2 of the window, zero means infinite
  localparam logic [DEP_W-1:0] DEP_INF = 4'h0;
  localparam logic [DEP_W-1:0] DEP_MIN = 4'h1;
  localparam logic [DEP_W-1:0] DEP_MAX = 4'hE;

  localparam logic [CODE_W-1:0] RC_OK      = 10'h000;
  localparam logic [CODE_W-1:0] RC_RANGE   = 10'h001;
  localparam logic [CODE_W-1:0] RC_FULL    = 10'h002;
  localparam logic [CODE_W-1:0] RC_NOSIG   = 10'h003;
  localparam logic [CODE_W-1:0] RC_TIMEOUT = 10'h020;
  localparam logic [CODE_W-1:0] RC_OUTSEL  = 10'h20E;

  localparam int WAIT_MS  = 2000;
  localparam int CLK_MHZ  = 100;
  localparam int WAIT_CYC = WAIT_MS * 1000 * CLK_MHZ;

  typedef enum logic [3:0] {
    OP_MDEF  = 4'h0,
    OP_MNONE = 4'h1,
    OP_MSET  = 4'h2,
    OP_MRST  = 4'h3,
    OP_SDEF  = 4'h4,
    OP_SNONE = 4'h5,
    OP_SCLR  = 4'h6,
    OP_NSEL  = 4'h7,
    OP_QMAS  = 4'h8,
    OP_QSTA  = 4'h9
  } ms_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_QRY  = 2'b11
  } ms_state_t;
endpackage : ms_pkg

// ---- ms_fifo.sv ----
// Sample FIFO with registered output stage and registered ready
`timescale 1ns/1ps
module ms_fifo import ms_pkg::*; #(
  parameter int W = 40,
  parameter int D = FIFO_DEPTH
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("FIFO depth must be a power of two");
  end

  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic [AW:0]   nxt_cnt;
  logic          push;
  logic          pop;

  assign push    = in_valid_in && in_ready_out;
  assign pop     = (cnt_ff != '0) && (!out_valid_out || out_ready_in);
  assign nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wp_ff        <= '0;
      rp_ff        <= '0;
      cnt_ff       <= '0;
      in_ready_out <= 1'b1;
    end else begin
      wp_ff        <= wp_ff + AW'(push);
      rp_ff        <= rp_ff + AW'(pop);
      cnt_ff       <= nxt_cnt;
      in_ready_out <= nxt_cnt != (AW+1)'(D);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (pop) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem_ff[rp_ff];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule : ms_fifo

// ---- ms_stat_slot.sv ----
// One statistics slot: min, max and peak-to-peak over a window
`timescale 1ns/1ps
module ms_stat_slot import ms_pkg::*; #(
  parameter int W = VAL_W
) (
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  input  wire logic                en_in,
  input  wire logic [DEP_W-1:0]    dep_in,
  input  wire logic                clr_in,
  input  wire logic                smp_valid_in,
  input  wire logic signed [W-1:0] smp_in,
  output logic signed [W-1:0]      min_out,
  output logic signed [W-1:0]      max_out,
  output logic signed [W-1:0]      pp_out
);
  logic signed [W-1:0] lo_ff;
  logic signed [W-1:0] hi_ff;
  logic signed [W-1:0] nxt_lo;
  logic signed [W-1:0] nxt_hi;
  logic [15:0]         cnt_ff;
  logic [15:0]         lim;
  logic                inf;
  logic                last;

  assign inf    = dep_in == DEP_INF;
  assign lim    = 16'h0001 << dep_in;
  assign last   = !inf && (cnt_ff == lim - 16'h0001);
  assign nxt_lo = (cnt_ff == '0 || smp_in < lo_ff) ? smp_in : lo_ff;
  assign nxt_hi = (cnt_ff == '0 || smp_in > hi_ff) ? smp_in : hi_ff;

  // Window tracking, restarts on each full window or on clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff <= '0;
      lo_ff  <= '0;
      hi_ff  <= '0;
    end else if (!en_in || clr_in) begin
      cnt_ff <= '0;
    end else if (smp_valid_in) begin
      cnt_ff <= last ? '0 : (inf ? 16'h0001 : cnt_ff + 16'h0001);
      lo_ff  <= nxt_lo;
      hi_ff  <= nxt_hi;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      min_out <= '0;
      max_out <= '0;
      pp_out  <= '0;
    end else if (!en_in || clr_in) begin
      min_out <= '0;
      max_out <= '0;
      pp_out  <= '0;
    end else if (smp_valid_in && (last || inf)) begin
      min_out <= nxt_lo;
      max_out <= nxt_hi;
      pp_out  <= nxt_hi - nxt_lo;
    end
  end
endmodule : ms_stat_slot

// ---- ms_unit.sv ----
// Mastering and statistics unit: offset slots, stats slots, sample path
`timescale 1ns/1ps
module ms_unit import ms_pkg::*; #(
  parameter int          N        = N_SLOT,
  parameter int unsigned WAIT_CNT = WAIT_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              smp_valid_in,
  input  wire logic [SIG_W-1:0]  smp_sig_in,
  input  wire logic [VAL_W-1:0]  smp_val_in,
  output logic                   smp_ready_out,
  output logic                   out_valid_out,
  output logic [SIG_W-1:0]       out_sig_out,
  output logic [VAL_W-1:0]       out_val_out,
  input  wire logic              out_ready_in,
  input  wire logic              cmd_valid_in,
  input  wire ms_op_t            cmd_op_in,
  input  wire logic              cmd_all_in,
  input  wire logic [SIG_W-1:0]  cmd_sig_in,
  input  wire logic [VAL_W-1:0]  cmd_val_in,
  input  wire logic [DEP_W-1:0]  cmd_dep_in,
  output logic                   cmd_ready_out,
  output logic                   rsp_valid_out,
  output logic [CODE_W-1:0]      rsp_code_out,
  output logic                   rsp_last_out,
  output logic [3:0]             rsp_idx_out,
  output logic                   rsp_used_out,
  output logic                   rsp_active_out,
  output logic [SIG_W-1:0]       rsp_sig_out,
  output logic [DEP_W-1:0]       rsp_dep_out,
  output logic [VAL_W-1:0]       rsp_min_out,
  output logic [VAL_W-1:0]       rsp_max_out,
  output logic [VAL_W-1:0]       rsp_pp_out,
  output logic [N-1:0]           net_sel_out
);
  if (N < 1 || N > 16 || WAIT_CNT < 1) begin : g_chk
    $error("Slot count must be 1..16 and wait count nonzero");
  end

  //////////////////////////////////////////////////////////////////////
  // Slot state
  logic [N-1:0]             m_used_ff;
  logic [N-1:0]             m_act_ff;
  logic [N-1:0]             m_pend_ff;
  logic [SIG_W-1:0]         m_sig_ff [N];
  logic signed [VAL_W-1:0]  m_val_ff [N];
  logic signed [VAL_W-1:0]  m_off_ff [N];
  logic [N-1:0]             s_used_ff;
  logic [SIG_W-1:0]         s_src_ff [N];
  logic [DEP_W-1:0]         s_dep_ff [N];
  logic signed [VAL_W-1:0]  s_min [N];
  logic signed [VAL_W-1:0]  s_max [N];
  logic signed [VAL_W-1:0]  s_pp [N];

  ms_state_t                state_ff;
  logic [31:0]              tmr_ff;
  logic [3:0]               idx_ff;
  logic                     qsta_ff;

  //////////////////////////////////////////////////////////////////////
  // Command decode
  logic                     take;
  logic [N-1:0]             m_eq;
  logic [N-1:0]             m_free;
  logic [N-1:0]             m_tgt;
  logic [N-1:0]             m_sel;
  logic [N-1:0]             s_eq;
  logic [N-1:0]             s_free;
  logic [N-1:0]             s_tgt;
  logic [N-1:0]             s_sel;
  logic                     val_ok;
  logic                     dep_ok;
  logic                     do_mdef;
  logic                     do_mnone;
  logic                     do_mset;
  logic                     do_mrst;
  logic                     do_sdef;
  logic                     do_snone;
  logic                     do_sclr;
  logic                     timeout;
  logic [CODE_W-1:0]        imm_code;

  assign take   = cmd_valid_in && cmd_ready_out;
  assign m_free = ~m_used_ff;
  assign s_free = ~s_used_ff;
  // Redefining a signal reuses its slot, else the lowest free slot
  assign m_tgt  = (|m_eq) ? m_eq : (m_free & (~m_free + N'(1)));
  assign s_tgt  = (|s_eq) ? s_eq : (s_free & (~s_free + N'(1)));
  assign m_sel  = cmd_all_in ? m_used_ff : m_eq;
  assign s_sel  = cmd_all_in ? s_used_ff : s_eq;

  assign val_ok = ($signed(cmd_val_in) <= MASTER_LIM) &&
                  ($signed(cmd_val_in) >= -MASTER_LIM);
  assign dep_ok = (cmd_dep_in == DEP_INF) ||
                  (cmd_dep_in >= DEP_MIN && cmd_dep_in <= DEP_MAX);

  assign do_mdef  = take && cmd_op_in == OP_MDEF && val_ok && |m_tgt;
  assign do_mnone = take && cmd_op_in == OP_MNONE;
  assign do_mset  = take && cmd_op_in == OP_MSET && |m_sel;
  assign do_mrst  = take && cmd_op_in == OP_MRST;
  assign do_sdef  = take && cmd_op_in == OP_SDEF && dep_ok && |s_tgt;
  assign do_snone = take && cmd_op_in == OP_SNONE;
  assign do_sclr  = take && cmd_op_in == OP_SCLR;
  assign timeout  = state_ff == ST_WAIT && |m_pend_ff &&
                    tmr_ff == WAIT_CNT - 1;

  always_comb begin
    imm_code = RC_OK;
    case (cmd_op_in)
      OP_MDEF:  imm_code = !val_ok ? RC_RANGE : (|m_tgt ? RC_OK : RC_FULL);
      OP_MSET:  imm_code = |m_sel ? RC_OK : RC_NOSIG;
      OP_SDEF:  imm_code = !dep_ok ? RC_RANGE : (|s_tgt ? RC_OK : RC_FULL);
      OP_SNONE: imm_code = |(s_eq & net_sel_out) ? RC_OUTSEL : RC_OK;
      default:  imm_code = RC_OK;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Sample path: offset applied before the FIFO
  logic                     smp_take;
  logic signed [VAL_W-1:0]  adj;
  logic signed [VAL_W-1:0]  mval;

  assign smp_take = smp_valid_in && smp_ready_out;

  always_comb begin
    adj = '0;
    for (int i = 0; i < N; i++) begin
      if (m_act_ff[i] && m_sig_ff[i] == smp_sig_in) begin
        adj = m_off_ff[i];
      end
    end
  end

  assign mval = $signed(smp_val_in) + adj;

  ms_fifo #(
    .W (SIG_W + VAL_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (smp_valid_in),
    .in_data_in    ({smp_sig_in, mval}),
    .in_ready_out  (smp_ready_out),
    .out_valid_out (out_valid_out),
    .out_data_out  ({out_sig_out, out_val_out}),
    .out_ready_in  (out_ready_in)
  );

  //////////////////////////////////////////////////////////////////////
  // Per-slot state
  for (genvar i = 0; i < N; i++) begin : g_slot
    logic cap;

    assign m_eq[i] = m_used_ff[i] && m_sig_ff[i] == cmd_sig_in;
    assign s_eq[i] = s_used_ff[i] && s_src_ff[i] == cmd_sig_in;
    assign cap     = m_pend_ff[i] && smp_take && smp_sig_in == m_sig_ff[i];

    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        m_used_ff[i] <= 1'b0;
        m_sig_ff[i]  <= '0;
        m_val_ff[i]  <= '0;
      end else if (do_mdef && m_tgt[i]) begin
        m_used_ff[i] <= 1'b1;
        m_sig_ff[i]  <= cmd_sig_in;
        m_val_ff[i]  <= $signed(cmd_val_in);
      end else if (do_mnone && m_eq[i]) begin
        m_used_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        m_act_ff[i]  <= 1'b0;
        m_pend_ff[i] <= 1'b0;
        m_off_ff[i]  <= '0;
      end else if (cap) begin
        m_act_ff[i]  <= 1'b1;
        m_pend_ff[i] <= 1'b0;
        m_off_ff[i]  <= m_val_ff[i] - $signed(smp_val_in);
      end else if (timeout) begin
        m_pend_ff[i] <= 1'b0;
      end else if (do_mset && m_sel[i]) begin
        m_pend_ff[i] <= 1'b1;
      end else if ((do_mrst && m_sel[i]) || (do_mnone && m_eq[i])) begin
        m_act_ff[i]  <= 1'b0;
        m_off_ff[i]  <= '0;
      end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        s_used_ff[i] <= 1'b0;
        s_src_ff[i]  <= '0;
        s_dep_ff[i]  <= DEP_INF;
      end else if (do_sdef && s_tgt[i]) begin
        s_used_ff[i] <= 1'b1;
        s_src_ff[i]  <= cmd_sig_in;
        s_dep_ff[i]  <= cmd_dep_in;
      end else if (do_snone && s_eq[i]) begin
        s_used_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        net_sel_out[i] <= 1'b0;
      end else if (take && cmd_op_in == OP_NSEL) begin
        net_sel_out[i] <= cmd_val_in[i];
      end else if (do_snone && s_eq[i]) begin
        net_sel_out[i] <= 1'b0;
      end
    end

    ms_stat_slot #(
      .W (VAL_W)
    ) u_stat (
      .clk_in       (clk_in),
      .nrst_in      (nrst_in),
      .en_in        (s_used_ff[i]),
      .dep_in       (s_dep_ff[i]),
      .clr_in       ((do_sclr && s_sel[i]) || (do_sdef && s_tgt[i])),
      .smp_valid_in (smp_take && smp_sig_in == s_src_ff[i]),
      .smp_in       (mval),
      .min_out      (s_min[i]),
      .max_out      (s_max[i]),
      .pp_out       (s_pp[i])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // Control sequence
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff      <= ST_IDLE;
      cmd_ready_out <= 1'b1;
      tmr_ff        <= '0;
      idx_ff        <= '0;
      qsta_ff       <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          tmr_ff <= '0;
          idx_ff <= '0;
          if (do_mset) begin
            state_ff      <= ST_WAIT;
            cmd_ready_out <= 1'b0;
          end else if (take && (cmd_op_in == OP_QMAS || cmd_op_in == OP_QSTA)) begin
            state_ff      <= ST_QRY;
            cmd_ready_out <= 1'b0;
            qsta_ff       <= cmd_op_in == OP_QSTA;
          end
        end
        ST_WAIT: begin
          tmr_ff <= tmr_ff + 32'h0000_0001;
          if (!(|m_pend_ff) || timeout) begin
            state_ff      <= ST_IDLE;
            cmd_ready_out <= 1'b1;
          end
        end
        ST_QRY: begin
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == 4'(N - 1)) begin
            state_ff      <= ST_IDLE;
            cmd_ready_out <= 1'b1;
          end
        end
        default: begin
          state_ff      <= ST_IDLE;
          cmd_ready_out <= 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Responses
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_valid_out  <= 1'b0;
      rsp_code_out   <= RC_OK;
      rsp_last_out   <= 1'b0;
      rsp_idx_out    <= '0;
      rsp_used_out   <= 1'b0;
      rsp_active_out <= 1'b0;
      rsp_sig_out    <= '0;
      rsp_dep_out    <= DEP_INF;
      rsp_min_out    <= '0;
      rsp_max_out    <= '0;
      rsp_pp_out     <= '0;
    end else begin
      rsp_valid_out <= 1'b0;
      rsp_last_out  <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (take && cmd_op_in != OP_QMAS && cmd_op_in != OP_QSTA &&
              !do_mset) begin
            rsp_valid_out <= 1'b1;
            rsp_last_out  <= 1'b1;
            rsp_code_out  <= imm_code;
          end
        end
        ST_WAIT: begin
          if (!(|m_pend_ff) || timeout) begin
            rsp_valid_out <= 1'b1;
            rsp_last_out  <= 1'b1;
            rsp_code_out  <= timeout ? RC_TIMEOUT : RC_OK;
          end
        end
        ST_QRY: begin
          rsp_valid_out <= 1'b1;
          rsp_last_out  <= idx_ff == 4'(N - 1);
          rsp_code_out  <= RC_OK;
          rsp_idx_out   <= idx_ff;
          if (qsta_ff) begin
            rsp_used_out   <= s_used_ff[idx_ff];
            rsp_active_out <= s_used_ff[idx_ff];
            rsp_sig_out    <= s_src_ff[idx_ff];
            rsp_dep_out    <= s_dep_ff[idx_ff];
            rsp_min_out    <= s_min[idx_ff];
            rsp_max_out    <= s_max[idx_ff];
            rsp_pp_out     <= s_pp[idx_ff];
          end else begin
            rsp_used_out   <= m_used_ff[idx_ff];
            rsp_active_out <= m_act_ff[idx_ff];
            rsp_sig_out    <= m_sig_ff[idx_ff];
            rsp_dep_out    <= DEP_INF;
            rsp_min_out    <= m_val_ff[idx_ff];
            rsp_max_out    <= m_off_ff[idx_ff];
            rsp_pp_out     <= '0;
          end
        end
        default: begin
          rsp_valid_out <= 1'b0;
        end
      endcase
    end
  end
endmodule : ms_unit

// ---- ms_unit_monitor.sv ----
// Concurrent checks on the ports of the mastering and statistics unit
`timescale 1ns/1ps
module ms_unit_chk import ms_pkg::*; (
  input wire logic              clk_in,
  input wire logic              nrst_in,
  input wire logic              smp_valid_in,
  input wire logic              smp_ready_out,
  input wire logic              out_valid_out,
  input wire logic [SIG_W-1:0]  out_sig_out,
  input wire logic [VAL_W-1:0]  out_val_out,
  input wire logic              out_ready_in,
  input wire logic              cmd_valid_in,
  input wire ms_op_t            cmd_op_in,
  input wire logic [VAL_W-1:0]  cmd_val_in,
  input wire logic              cmd_ready_out,
  input wire logic              rsp_valid_out,
  input wire logic [CODE_W-1:0] rsp_code_out,
  input wire logic              rsp_last_out,
  input wire logic [3:0]        rsp_idx_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic take;
  assign take = cmd_valid_in && cmd_ready_out;
  a_out_stall_hold: assert property (out_valid_out && !out_ready_in |=> out_valid_out
    && $stable(out_val_out) && $stable(out_sig_out)) else $error("sample changed in stall");
  a_mdef_range_err: assert property (take && cmd_op_in == OP_MDEF
    && ($signed(cmd_val_in) > MASTER_LIM || $signed(cmd_val_in) < -MASTER_LIM)
    |=> rsp_valid_out && rsp_code_out == RC_RANGE) else $error("range not refused");
  a_mdef_answer: assert property (take && cmd_op_in == OP_MDEF |=> rsp_valid_out
    && rsp_last_out) else $error("define without answer");
  a_qmas_first_line: assert property (take && cmd_op_in == OP_QMAS |-> ##2 rsp_valid_out
    && rsp_idx_out == 4'h0 && !rsp_last_out) else $error("query first line wrong");
  a_query_busy: assert property (take && cmd_op_in inside {OP_QMAS, OP_QSTA}
    |=> !cmd_ready_out [*8]) else $error("ready during query");
  a_last_ready: assert property (rsp_valid_out && rsp_last_out |=> cmd_ready_out
    && !rsp_valid_out) else $error("no ready after last line");
  a_timeout_last: assert property (rsp_valid_out && rsp_code_out == RC_TIMEOUT
    |-> rsp_last_out) else $error("timeout not final");
  a_smp_reach_out: assert property (smp_valid_in && smp_ready_out && !out_valid_out
    |-> ##[2:12] out_valid_out) else $error("sample lost");
endmodule : ms_unit_chk
bind ms_unit ms_unit_chk i_chk (.*);

// ---- ms_sink.sv ----
// Consumer model of the mastered sample stream, able to stall
`timescale 1ns/1ps
module ms_sink (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [1:0] mode_in,
  output logic            ready_out
);
  logic [7:0] lfsr_ff;
  // Mode 0 takes every cycle, 1 stalls at random, 2 holds off
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lfsr_ff <= 8'hA5;
      ready_out <= 1'b0;
    end else begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && lfsr_ff[0]);
    end
  end
endmodule : ms_sink

// ---- ms_unit_tb.sv ----
// Self-checking bench of the mastering and statistics unit
`timescale 1ns/1ps
module ms_unit_tb import ms_pkg::*;;
  typedef struct packed {logic [1:0] k; logic [CODE_W-1:0] cd; logic u; logic a;
    logic [SIG_W-1:0] sg; logic [DEP_W-1:0] dp; logic [95:0] st;} ms_exp_t;
  logic clk_in, nrst_in, s_vld, s_rdy, o_vld, o_rdy, c_vld, c_all, c_rdy;
  logic r_vld, r_last, r_used, r_act;
  logic [7:0] s_sig, o_sig, c_sig, r_sig;
  logic [31:0] s_val, o_val, c_val, r_min, r_max, r_pp, v, w, a, b;
  logic [3:0] c_dep, r_dep, r_idx;
  logic [9:0] r_code, nsel;
  logic [1:0] mode;
  ms_op_t c_op;
  ms_exp_t rq[$], e;
  logic [40:0] sq[$], x;
  logic signed [31:0] mn, mx;
  logic [31:0] rs = 32'h0000_2A03; // Seed 10755
  int n_fail = 0, total_checks = 0, n;

  ms_unit #(.WAIT_CNT(50)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .smp_valid_in(s_vld),
    .smp_sig_in(s_sig), .smp_val_in(s_val), .smp_ready_out(s_rdy), .out_valid_out(o_vld),
    .out_sig_out(o_sig), .out_val_out(o_val), .out_ready_in(o_rdy), .cmd_valid_in(c_vld),
    .cmd_op_in(c_op), .cmd_all_in(c_all), .cmd_sig_in(c_sig), .cmd_val_in(c_val),
    .cmd_dep_in(c_dep), .cmd_ready_out(c_rdy), .rsp_valid_out(r_vld), .rsp_code_out(r_code),
    .rsp_last_out(r_last), .rsp_idx_out(r_idx), .rsp_used_out(r_used), .rsp_active_out(r_act),
    .rsp_sig_out(r_sig), .rsp_dep_out(r_dep), .rsp_min_out(r_min), .rsp_max_out(r_max),
    .rsp_pp_out(r_pp), .net_sel_out(nsel));
  ms_sink i_sink (.clk_in(clk_in), .nrst_in(nrst_in), .mode_in(mode), .ready_out(o_rdy));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rv();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return {{12{rs[31]}}, rs[31:12]};
  endfunction : rv

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic cmd(input ms_op_t op, input logic al, input logic [7:0] sg,
                     input logic [31:0] vl, input logic [3:0] dp);
    do @(negedge clk_in); while (rq.size() != 0 || c_rdy !== 1'b1);
    @(posedge clk_in);
    c_vld <= 1'b1;
    c_op <= op;
    c_all <= al;
    c_sig <= sg;
    c_val <= vl;
    c_dep <= dp;
    do @(negedge clk_in); while (c_rdy !== 1'b1);
    @(posedge clk_in);
    c_vld <= 1'b0;
  endtask : cmd

  task automatic smp(input logic [7:0] sg, input logic [31:0] vl, input logic cr,
                     input logic [31:0] ev);
    @(posedge clk_in);
    s_vld <= 1'b1;
    s_sig <= sg;
    s_val <= vl;
    do @(negedge clk_in); while (s_rdy !== 1'b1);
    @(posedge clk_in);
    sq.push_back({cr, sg, ev});
    s_vld <= 1'b0;
  endtask : smp

  task automatic ec(input logic [CODE_W-1:0] cd);
    rq.push_back('{2'h0, cd, 1'b0, 1'b0, 8'h00, 4'h0, 96'h0});
  endtask : ec

  task automatic qm(input logic [7:0] s0, input logic [7:0] s1, input logic a0, input logic a1);
    for (int i = 0; i < N_SLOT; i++) begin
      if (i == 0 && s0 != 8'h00) rq.push_back('{2'h1, RC_OK, 1'b1, a0, s0, 4'h0, 96'h0});
      else if (i == 1) rq.push_back('{2'h1, RC_OK, 1'b1, a1, s1, 4'h0, 96'h0});
      else rq.push_back('{2'h2, RC_OK, 1'b0, 1'b0, 8'h00, 4'h0, 96'h0});
    end
  endtask : qm

  task automatic qs(input logic [3:0] dp, input logic [95:0] st);
    rq.push_back('{2'h3, RC_OK, 1'b1, 1'b1, 8'h09, dp, st});
    for (int i = 1; i < N_SLOT; i++) rq.push_back('{2'h2, RC_OK, 1'b0, 1'b0, 8'h0, 4'h0, 96'h0});
  endtask : qs

  task automatic drain();
    while (sq.size() != 0 || rq.size() != 0) @(negedge clk_in);
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    if (r_vld === 1'b1) begin
      check(rq.size() != 0, 1'b1);
      e = rq.pop_front();
      case (e.k)
        2'h0: check(r_code, e.cd);
        2'h1: check({r_used, r_act, r_sig}, {e.u, e.a, e.sg});
        2'h2: check(r_used, 1'b0);
        default: begin
          check({r_used, r_sig, r_dep}, {1'b1, e.sg, e.dp});
          check({r_min, r_max, r_pp}, e.st);
        end
      endcase
    end
    if (o_vld === 1'b1 && o_rdy === 1'b1) begin
      check(sq.size() != 0, 1'b1);
      x = sq.pop_front();
      if (x[40]) check({o_sig, o_val}, x[39:0]);
    end
  end

  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  initial begin
    {nrst_in, s_vld, c_vld, c_all, mode} = '0;
    {s_sig, s_val, c_sig, c_val, c_dep} = '0;
    c_op = OP_MDEF;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    cmd(OP_MDEF, 1'b0, 8'h05, 32'd422000, 4'h0); ec(RC_OK);
    cmd(OP_MDEF, 1'b0, 8'h06, MASTER_LIM + 1, 4'h0); ec(RC_RANGE);
    cmd(OP_MDEF, 1'b0, 8'h07, -MASTER_LIM, 4'h0); ec(RC_OK);
    cmd(OP_QMAS, 1'b0, 8'h00, 32'h0, 4'h0); qm(8'h05, 8'h07, 1'b0, 1'b0);
    v = rv();
    smp(8'h05, v, 1'b1, v);
    drain();
    cmd(OP_MSET, 1'b0, 8'h05, 32'h0, 4'h0); ec(RC_OK);
    v = rv();
    w = rv();
    smp(8'h05, v, 1'b0, 32'h0);
    smp(8'h05, w, 1'b1, w + 32'd422000 - v);
    cmd(OP_QMAS, 1'b0, 8'h00, 32'h0, 4'h0); qm(8'h05, 8'h07, 1'b1, 1'b0);
    cmd(OP_MRST, 1'b0, 8'h05, 32'h0, 4'h0); ec(RC_OK);
    smp(8'h05, w, 1'b1, w);
    cmd(OP_MDEF, 1'b0, 8'h07, 32'h0, 4'h0); ec(RC_OK);
    drain();
    cmd(OP_MSET, 1'b1, 8'h00, 32'h0, 4'h0); ec(RC_OK);
    a = rv();
    b = rv();
    smp(8'h05, a, 1'b0, 32'h0);
    smp(8'h07, b, 1'b0, 32'h0);
    v = rv();
    smp(8'h07, v, 1'b1, v - b);
    smp(8'h05, v, 1'b1, v + 32'd422000 - a);
    drain();
    cmd(OP_MSET, 1'b0, 8'h05, 32'h0, 4'h0); ec(RC_TIMEOUT);
    cmd(OP_MNONE, 1'b0, 8'h05, 32'h0, 4'h0); ec(RC_OK);
    cmd(OP_MSET, 1'b0, 8'h05, 32'h0, 4'h0); ec(RC_NOSIG);
    cmd(OP_QMAS, 1'b0, 8'h00, 32'h0, 4'h0); qm(8'h00, 8'h07, 1'b0, 1'b1);
    cmd(OP_SDEF, 1'b0, 8'h09, 32'h0, 4'h8); ec(RC_OK);
    mode <= 2'h1;
    mn = 32'sh7FFF_FFFF;
    mx = 32'sh8000_0000;
    for (int i = 0; i < 256; i++) begin
      v = rv();
      if ($signed(v) < mn) mn = v;
      if ($signed(v) > mx) mx = v;
      smp(8'h09, v, 1'b1, v);
    end
    drain();
    cmd(OP_QSTA, 1'b0, 8'h00, 32'h0, 4'h0); qs(4'h8, {mn, mx, mx - mn});
    cmd(OP_SCLR, 1'b1, 8'h00, 32'h0, 4'h0); ec(RC_OK);
    cmd(OP_QSTA, 1'b0, 8'h00, 32'h0, 4'h0); qs(4'h8, 96'h0);
    cmd(OP_SDEF, 1'b0, 8'h09, 32'h0, 4'hF); ec(RC_RANGE);
    cmd(OP_SDEF, 1'b0, 8'h09, 32'h0, DEP_INF); ec(RC_OK);
    a = rv();
    b = rv();
    smp(8'h09, a, 1'b1, a);
    smp(8'h09, b, 1'b1, b);
    drain();
    mn = ($signed(a) < $signed(b)) ? a : b;
    mx = ($signed(a) < $signed(b)) ? b : a;
    cmd(OP_QSTA, 1'b0, 8'h00, 32'h0, 4'h0); qs(DEP_INF, {mn, mx, mx - mn});
    cmd(OP_NSEL, 1'b0, 8'h00, 32'h1, 4'h0); ec(RC_OK);
    drain();
    check(nsel, 10'h001);
    cmd(OP_SNONE, 1'b0, 8'h09, 32'h0, 4'h0); ec(RC_OUTSEL);
    drain();
    check(nsel, 10'h000);
    mode <= 2'h2;
    n = 0;
    @(posedge clk_in);
    s_vld <= 1'b1;
    s_sig <= 8'h08;
    s_val <= 32'h0000_0100;
    repeat (16) begin
      @(negedge clk_in);
      if (s_rdy === 1'b1) begin
        n++;
        sq.push_back({1'b1, 8'h08, 32'h0000_0100});
      end
    end
    @(posedge clk_in);
    s_vld <= 1'b0;
    check(n, FIFO_DEPTH + 1);
    mode <= 2'h0;
    drain();
    stop_test();
  end
endmodule : ms_unit_tb
